// ---- hw/byte_stream_if.sv ----
`timescale 1ns/1ps
// valid/ready byte stream between internal stages
interface byte_stream_if;
    import link_recovery_pkg::*;
    logic              valid;  // word offered
    logic              ready;  // word taken
    logic [DATA_W-1:0] data;   // byte value
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// ---- hw/dual_mode_link_recovery_ctrl.sv ----
`timescale 1ns/1ps
// mode control, transmit-only stream and write gating
module dual_mode_link_recovery_ctrl #(
    parameter int TIME_BASE_CYC = link_recovery_pkg::TIME_BASE_CYCLES,
    parameter int TIMEOUT_TICKS = link_recovery_pkg::FALLBACK_TIMEOUT_MS
) (
    // clock and reset
    input  wire logic                                ref_clk_i,
    input  wire logic                                resetn_i,
    // link pins
    input  wire logic                                transmit_only_clock_i,
    input  wire logic                                scl_i,
    input  wire logic                                sda_i,
    output logic                                     sda_o,
    output logic                                     sda_oe_n_o,
    input  wire logic                                write_protect_input_i,
    // variant strap: high when the write-control pin exists
    input  wire logic                                has_wc_pin_i,
    // memory read port, combinational read
    output logic [link_recovery_pkg::ADDR_W-1:0]     mem_addr_o,
    input  wire logic [link_recovery_pkg::DATA_W-1:0] mem_data_i,
    // two-wire protocol engine
    input  wire logic                                engine_sda_pull_i,
    input  wire logic                                engine_wr_commit_i,
    output logic                                     prog_start_o,
    output logic                                     write_enable_o,
    // status
    output link_recovery_pkg::link_mode_e            mode_o
);
    import link_recovery_pkg::*;

    // synchronised pins
    logic [3:0] pins_sync;
    logic       transmit_only_clock_s;          // transmit-only clock level
    logic       scl_s;           // two-wire clock level
    logic       sda_s;           // data line level
    logic       wp_s;            // write-control level
    logic       transmit_only_clock_d_reg;      // previous clock levels for edges
    logic       scl_d_reg;
    logic       sda_d_reg;
    logic       transmit_only_clock_rise;
    logic       scl_fall;
    logic       scl_rise;
    logic       start_det;
    logic       stop_det;

    // mode state
    link_mode_e mode_reg;
    link_mode_e mode_next;

    // transmit-only stream state
    logic [ADDR_W-1:0] addr_reg;      // fetch address
    logic [3:0]        init_cnt_reg;  // pulses seen since power-up
    logic              init_done;
    logic [3:0]        bit_cnt_reg;   // position within a byte
    logic [DATA_W-1:0] shift_reg;     // byte being sent
    logic              tx_bit_reg;    // bit on the line, 1 = released
    logic              tx_take;

    // fallback counters
    logic [7:0]           pulse_cnt_reg;
    logic [TIMEBASE_W-1:0] tb_cnt_reg;
    logic                 tb_tick;
    logic [TIMEOUT_W-1:0] tmo_cnt_reg;
    logic                 fallback;

    // device select watcher
    logic              sel_active_reg;  // shifting after a start
    logic [3:0]        sel_cnt_reg;
    logic [DATA_W-1:0] sel_shift_reg;
    logic              sel_valid;

    // write gating
    logic              wr_allow;

    byte_stream_if fetch_s ();
    byte_stream_if drain_s ();

    // every pin crosses two flops before use
    sync_2ff #(
        .W (4)
    ) u_pin_sync (
        .ref_clk_i (ref_clk_i),
        .resetn_i  (resetn_i),
        .async_i   ({transmit_only_clock_i, scl_i, sda_i, write_protect_input_i}),
        .sync_o    (pins_sync)
    );
    assign transmit_only_clock_s = pins_sync[3];
    assign scl_s  = pins_sync[2];
    assign sda_s  = pins_sync[1];
    assign wp_s   = pins_sync[0];

    // edge history; resets low like the synchroniser so release shows no false fall
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            transmit_only_clock_d_reg <= 1'b0;
            scl_d_reg  <= 1'b0;
            sda_d_reg  <= 1'b0;
        end else begin
            transmit_only_clock_d_reg <= transmit_only_clock_s;
            scl_d_reg  <= scl_s;
            sda_d_reg  <= sda_s;
        end
    end

    assign transmit_only_clock_rise = transmit_only_clock_s && !transmit_only_clock_d_reg;
    assign scl_fall  = !scl_s && scl_d_reg;
    assign scl_rise  = scl_s && !scl_d_reg;
    // start and stop: data moves while clock stays high
    assign start_det = scl_s && scl_d_reg && sda_d_reg && !sda_s;
    assign stop_det  = scl_s && scl_d_reg && !sda_d_reg && sda_s;

    // device select watcher, sampled on two-wire clock rises
    // type code in top nibble, rest ignored
    assign sel_valid = sel_active_reg && (sel_cnt_reg == SEL_BITS)
                       && (sel_shift_reg[SEL_TYPE_HI:SEL_TYPE_LO] == DEV_TYPE_CODE);

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            sel_active_reg <= 1'b0;
            sel_cnt_reg    <= 4'h0;
            sel_shift_reg  <= 8'h00;
        end else if (start_det) begin
            // a repeated start restarts the byte
            sel_active_reg <= 1'b1;
            sel_cnt_reg    <= 4'h0;
        end else if (stop_det || (sel_cnt_reg == SEL_BITS)) begin
            // only the first byte after a start matters here
            sel_active_reg <= 1'b0;
            sel_cnt_reg    <= 4'h0;
        end else if (sel_active_reg && scl_rise) begin
            // bits taken on two-wire clock rise
            sel_shift_reg <= {sel_shift_reg[DATA_W-2:0], sda_s};
            sel_cnt_reg   <= sel_cnt_reg + 4'h1;
        end
    end

    // internal time base, one pulse per tick
    // prescaler feeding the timeout counter
    assign tb_tick = (tb_cnt_reg == TIMEBASE_W'(TIME_BASE_CYC - 1));

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            tb_cnt_reg <= '0;
        end else if (mode_reg != MODE_TRANSITION || scl_fall || tb_tick) begin
            tb_cnt_reg <= '0;
        end else begin
            tb_cnt_reg <= tb_cnt_reg + TIMEBASE_W'(1);
        end
    end

    // fallback counters, live only in the transition state
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            pulse_cnt_reg <= 8'h00;
            tmo_cnt_reg   <= '0;
        end else if (mode_reg != MODE_TRANSITION) begin
            pulse_cnt_reg <= 8'h00;
            tmo_cnt_reg   <= '0;
        end else if (scl_fall) begin
            pulse_cnt_reg <= 8'h00;
            tmo_cnt_reg   <= '0;
        end else begin
            if (transmit_only_clock_rise && pulse_cnt_reg != FALLBACK_PULSES) begin
                pulse_cnt_reg <= pulse_cnt_reg + 8'h01;
            end
            if (tb_tick && tmo_cnt_reg != TIMEOUT_W'(TIMEOUT_TICKS)) begin
                tmo_cnt_reg <= tmo_cnt_reg + TIMEOUT_W'(1);
            end
        end
    end

    // pulse count or timeout ends transition
    assign fallback = (pulse_cnt_reg == FALLBACK_PULSES)
                      || (tmo_cnt_reg == TIMEOUT_W'(TIMEOUT_TICKS));

    // mode selection; valid select beats fallback in the same cycle
    always_comb begin
        mode_next = mode_reg;
        case (mode_reg)
            MODE_TX_ONLY: begin
                if (scl_fall) begin
                    mode_next = MODE_TRANSITION;
                end
            end
            MODE_TRANSITION: begin
                if (sel_valid) begin
                    mode_next = MODE_LOCKED;
                end else if (fallback && !scl_fall) begin
                    mode_next = MODE_TX_ONLY;
                end
            end
            MODE_LOCKED: begin
                // no way back until power is removed
                mode_next = MODE_LOCKED;
            end
            default: begin
                mode_next = MODE_TX_ONLY;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            mode_reg <= MODE_TX_ONLY;
        end else begin
            mode_reg <= mode_next;
        end
    end
    assign mode_o = mode_reg;

    // fetch side: memory bytes offered in address order
    assign mem_addr_o    = addr_reg;
    assign fetch_s.valid = (mode_reg == MODE_TX_ONLY);
    assign fetch_s.data  = mem_data_i;

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            addr_reg <= ADDR_RESET;
        end else if (fetch_s.valid && fetch_s.ready) begin
            addr_reg <= addr_reg + ADDR_W'(1);
        end
    end

    // buffer so a late pulse never drops a fetched byte
    stream_buf2 u_buf (
        .ref_clk_i (ref_clk_i),
        .resetn_i  (resetn_i),
        .in_s      (fetch_s),
        .out_s     (drain_s)
    );

    // a byte is taken at the first pulse of a byte slot
    assign init_done     = (init_cnt_reg == INIT_PULSES);
    assign tx_take       = (mode_reg == MODE_TX_ONLY) && transmit_only_clock_rise && init_done
                           && (bit_cnt_reg == 4'h0);
    assign drain_s.ready = tx_take;

    // power-up pulse counter; kept after a fallback
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            init_cnt_reg <= 4'h0;
        end else if (mode_reg == MODE_TX_ONLY && transmit_only_clock_rise && !init_done) begin
            init_cnt_reg <= init_cnt_reg + 4'h1;
        end
    end

    // serialiser, advanced only by transmit-only clock rises
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            bit_cnt_reg <= 4'h0;
            shift_reg   <= 8'h00;
            tx_bit_reg  <= 1'b1;
        end else if (mode_reg != MODE_TX_ONLY) begin
            // leave a clean byte boundary for a later fallback
            bit_cnt_reg <= 4'h0;
            tx_bit_reg  <= 1'b1;
        end else if (transmit_only_clock_rise && init_done) begin
            if (bit_cnt_reg == 4'h0) begin
                if (drain_s.valid) begin
                    // msb first
                    tx_bit_reg  <= drain_s.data[DATA_W-1];
                    shift_reg   <= {drain_s.data[DATA_W-2:0], 1'b0};
                    bit_cnt_reg <= 4'h1;
                end else begin
                    // underrun: stay released and retry next pulse
                    tx_bit_reg <= 1'b1;
                end
            end else if (bit_cnt_reg <= BIT_LAST_DATA) begin
                tx_bit_reg  <= shift_reg[DATA_W-1];
                shift_reg   <= {shift_reg[DATA_W-2:0], 1'b0};
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end else begin
                // ninth pulse carries a don't-care, released
                tx_bit_reg  <= 1'b1;
                bit_cnt_reg <= 4'h0;
            end
        end
    end

    // data line: open drain only
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            sda_oe_n_o <= 1'b1;
        end else if (mode_reg == MODE_TX_ONLY) begin
            // zero bits pull low, ones release
            sda_oe_n_o <= tx_bit_reg;
        end else begin
            // engine drives on its own bus clock timing
            sda_oe_n_o <= !engine_sda_pull_i;
        end
    end
    // the driven level is only ever low
    assign sda_o = 1'b0;

    // write permission, meaningful in two-wire modes
    always_comb begin
        if (has_wc_pin_i) begin
            wr_allow = wp_s;
        end else begin
            // transmit clock doubles as write enable
            wr_allow = transmit_only_clock_s;
        end
    end

    // engine acks regardless; only programming is gated
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            write_enable_o <= 1'b0;
            prog_start_o   <= 1'b0;
        end else begin
            write_enable_o <= wr_allow && (mode_reg != MODE_TX_ONLY);
            prog_start_o   <= engine_wr_commit_i && wr_allow
                              && (mode_reg != MODE_TX_ONLY);
        end
    end

endmodule

// ---- hw/link_recovery_pkg.sv ----
// Summary of operation
// - first two-wire entry goes provisional, acts normally
// - fallback after 128 pulses or timeout
// - valid device select locks two-wire mode permanently
// - two-wire clock fall restarts both fallback counters
// - transmit-only data advances on its own clock
// - no-pin variant: transmit clock high enables writes
// - write-control low protects, high allows writes
// - data line only pulled low or released
// - two-wire data timed by two-wire clock
// - power-up: nine released pulses, data on tenth
// - nine pulses per byte, address wraps
// - two-wire clock fall leaves transmit-only mode
// - device select: type code, three ignored, direction
package link_recovery_pkg;

    // operating modes of the link
    typedef enum logic [1:0] {
        MODE_TX_ONLY,
        MODE_TRANSITION,
        MODE_LOCKED
    } link_mode_e;

    // memory geometry
    localparam int          ADDR_W          = 7;
    localparam int          DATA_W          = 8;
    localparam logic [6:0]  ADDR_RESET      = 7'h00;

    // transmit-only framing
    localparam logic [3:0]  INIT_PULSES     = 4'h9;  // released pulses after power-up
    localparam logic [3:0]  BIT_LAST_DATA   = 4'h7;  // last data bit index
    localparam logic [3:0]  BIT_DONT_CARE   = 4'h8;  // ninth pulse of a byte
    localparam logic [7:0]  FALLBACK_PULSES = 8'h80; // 128 pulses in transition state

    // device select layout, msb first
    localparam int          SEL_TYPE_HI     = 7;
    localparam int          SEL_TYPE_LO     = 4;
    localparam logic [3:0]  SEL_BITS        = 4'h8;
    // device type code: value is arbitrary
    localparam logic [3:0]  DEV_TYPE_CODE   = 4'h6;

    // timing: clock 125 MHz
    localparam int          CLK_PERIOD_PS        = 8000;
    localparam int          TIME_BASE_NS         = 1000000;  // 1 ms tick
    localparam int          TIME_BASE_CYCLES     = TIME_BASE_NS * 1000 / CLK_PERIOD_PS;
    localparam int          FALLBACK_TIMEOUT_MS  = 2000;     // about 2 s
    localparam int          TIMEBASE_W           = 24;
    localparam int          TIMEOUT_W            = 12;

endpackage

// ---- hw/stream_buf2.sv ----
`timescale 1ns/1ps
// two-entry buffer; keeps words when the drain stalls
module stream_buf2 (
    // clock and reset
    input  wire logic ref_clk_i,
    input  wire logic resetn_i,
    // filling and draining sides
    byte_stream_if.snk in_s,
    byte_stream_if.src out_s
);
    import link_recovery_pkg::*;

    logic [DATA_W-1:0] mem_reg [2];  // storage
    logic              wr_ptr_reg;   // next slot to fill
    logic              rd_ptr_reg;   // next slot to drain
    logic [1:0]        count_reg;    // occupancy
    logic              push;
    logic              pop;

    // honest full and empty
    assign in_s.ready  = (count_reg != 2'h2);
    assign out_s.valid = (count_reg != 2'h0);
    assign out_s.data  = mem_reg[rd_ptr_reg];
    assign push        = in_s.valid && in_s.ready;
    assign pop         = out_s.valid && out_s.ready;

    // storage writes
    always_ff @(posedge ref_clk_i) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_s.data;
        end
    end

    // pointers and count
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            count_reg  <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr_reg <= ~wr_ptr_reg;
            end
            if (pop) begin
                rd_ptr_reg <= ~rd_ptr_reg;
            end
            if (push && !pop) begin
                count_reg <= count_reg + 2'h1;
            end else if (pop && !push) begin
                count_reg <= count_reg - 2'h1;
            end
        end
    end
endmodule

// ---- hw/sync_2ff.sv ----
`timescale 1ns/1ps
// two-flop synchroniser for pin levels
module sync_2ff #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         ref_clk_i,
    input  wire logic         resetn_i,
    // level in and out
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);
    logic [W-1:0] meta_reg;  // first stage, read only by second

    // two stages; only the second is visible
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            meta_reg <= '0;
            sync_o   <= '0;
        end else begin
            meta_reg <= async_i;
            sync_o   <= meta_reg;
        end
    end
endmodule

// ---- test/display_host_model.sv ----
`timescale 1ns/1ps
// display host: transmit clock, two-wire master, write pin
module display_host_model (
    // pins towards the device
    output logic transmit_only_clock_o,    // transmit clock, still between bursts
    output logic scl_o,     // two-wire clock, high when idle
    output logic sda_low_o, // host pulls data low
    output logic wp_o       // write control level
);
    // idle: line released, unconnected write pin reads low
    initial begin
        transmit_only_clock_o = 1'b0;
        scl_o = 1'b1;
        sda_low_o = 1'b0;
        wp_o = 1'b0;
    end
    // static levels for the write gate
    task automatic set_pins(input logic v, input logic w);
        transmit_only_clock_o = v;
        wp_o = w;
    endtask
    // transmit clock pulses, 80 ns period; each call starts with a rising edge and ends low
    task automatic transmit_only_clock_pulses(input int n);
        repeat (n) begin
            transmit_only_clock_o = 1'b1;
            #40;
            transmit_only_clock_o = 1'b0;
            #40;
        end
    endtask
    // one clock pulse; data changes only while the clock is low
    task automatic bit_slot(input logic low);
        scl_o = 1'b0;
        #16;
        sda_low_o = low;
        #24;
        scl_o = 1'b1;
        #40;
    endtask
    // lone clock fall with data released
    task automatic scl_fall();
        bit_slot(1'b0);
    endtask
    // start, select msb first, acknowledge slot, stop
    task automatic send_select(input logic [7:0] sel);
        sda_low_o = 1'b1;
        #40;
        for (int i = 7; i >= 0; i--) begin
            bit_slot(!sel[i]);
        end
        bit_slot(1'b0);
        bit_slot(1'b1);
        sda_low_o = 1'b0;
        #40;
    endtask
endmodule

// ---- test/link_recovery_checker.sv ----
`timescale 1ns/1ps
// watches mode, write gate and data pin of the controller
module link_recovery_checker
    import link_recovery_pkg::*;
#(
    parameter int TIME_BASE_CYC = 10,
    parameter int TIMEOUT_TICKS = 5
) (
    // clock and reset
    input wire logic                          ref_clk_i,
    input wire logic                          resetn_i,
    // link pins
    input wire logic                          transmit_only_clock_i,
    input wire logic                          scl_i,
    input wire logic                          sda_o,
    input wire logic                          sda_oe_n_o,
    // engine side and status
    input wire logic                          engine_sda_pull_i,
    input wire logic                          engine_wr_commit_i,
    input wire logic                          prog_start_o,
    input wire logic                          write_enable_o,
    input wire link_recovery_pkg::link_mode_e mode_o
);
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!resetn_i);

    logic       transmit_only_clock_q;     // pin one clock late
    logic [3:0] since_rise; // clocks since last pin rise, saturates

    // age of the last transmit clock rise, raw pin so sync lag shows
    always_ff @(posedge ref_clk_i) begin
        transmit_only_clock_q <= transmit_only_clock_i;
        if (!resetn_i) begin
            since_rise <= 4'hf;
        end else if (transmit_only_clock_i && !transmit_only_clock_q) begin
            since_rise <= 4'h1;
        end else if (since_rise != 4'hf) begin
            since_rise <= since_rise + 4'h1;
        end
    end

    // three settled cycles in transmit-only mode
    sequence tx_steady;
        mode_o == MODE_TX_ONLY && $past(mode_o) == MODE_TX_ONLY && $past(mode_o, 2) == MODE_TX_ONLY;
    endsequence
    // a two-wire clock fall seen in a given mode
    sequence scl_fell_in(m);
        mode_o == m && $fell(scl_i);
    endsequence

    chk_sda_never_high: assert property (sda_o == 1'b0)
        else $error("data output not low");
    chk_oe_follows_engine: assert property ((mode_o == MODE_LOCKED && $past(mode_o) == MODE_LOCKED) |-> sda_oe_n_o == !$past(engine_sda_pull_i))
        else $error("data enable does not follow engine");
    chk_tx_oe_on_transmit_only_clock: assert property (tx_steady ##0 $changed(sda_oe_n_o) |-> since_rise inside {[2:8]})
        else $error("data changed without transmit clock rise");
    chk_enter_transition: assert property (scl_fell_in(MODE_TX_ONLY) |-> ##[1:6] mode_o == MODE_TRANSITION)
        else $error("no transition after clock fall");
    chk_lock_holds: assert property (mode_o == MODE_LOCKED |=> mode_o == MODE_LOCKED)
        else $error("left locked mode");
    chk_fall_restarts: assert property (scl_fell_in(MODE_TRANSITION) |-> ##6 (mode_o != MODE_TX_ONLY) [*8])
        else $error("fallback right after clock fall");
    chk_prog_cause: assert property (prog_start_o |-> $past(engine_wr_commit_i) && $past(mode_o) != MODE_TX_ONLY)
        else $error("programming without commit");
    chk_prog_allowed: assert property (engine_wr_commit_i && write_enable_o && $stable(write_enable_o) |=> prog_start_o)
        else $error("allowed write not programmed");
    chk_we_off_tx: assert property (tx_steady |-> !write_enable_o)
        else $error("write enable in transmit-only mode");
endmodule

bind dual_mode_link_recovery_ctrl link_recovery_checker #(
    .TIME_BASE_CYC(TIME_BASE_CYC),
    .TIMEOUT_TICKS(TIMEOUT_TICKS)
) chk_u (
    .ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .transmit_only_clock_i(transmit_only_clock_i),
    .scl_i(scl_i),
    .sda_o(sda_o),
    .sda_oe_n_o(sda_oe_n_o),
    .engine_sda_pull_i(engine_sda_pull_i),
    .engine_wr_commit_i(engine_wr_commit_i),
    .prog_start_o(prog_start_o),
    .write_enable_o(write_enable_o),
    .mode_o(mode_o)
);

// ---- test/testbench.sv ----
`timescale 1ns/1ps
// stream, mode recovery and write gating of the link controller
module testbench;
    import link_recovery_pkg::*;
    localparam int TB_CYC   = 100; // short time base tick
    localparam int TB_TICKS = 20;  // fallback after 2000 clocks

    logic              ref_clk_i          = 1'b0;
    logic              resetn_i           = 1'b0;
    logic              has_wc_pin_i;
    logic              engine_sda_pull_i;
    logic              engine_wr_commit_i;
    logic              transmit_only_clock, scl, sda_low, wp;     // host pins
    logic              sda_wire;                   // resolved line
    logic              sda_o, sda_oe_n_o, prog_start_o, write_enable_o;
    logic [ADDR_W-1:0] mem_addr_o;
    logic [DATA_W-1:0] mem_data_i;
    link_mode_e        mode_o;
    int                n_mismatch;
    int                comparisons;

    // free running clock
    always #4 ref_clk_i = ~ref_clk_i;
    // a pattern that differs at every address
    assign mem_data_i = {mem_addr_o, 1'b0} ^ 8'ha5;
    // open drain with pull-up
    assign sda_wire = sda_oe_n_o & !sda_low;

    display_host_model host_u (
        .transmit_only_clock_o(transmit_only_clock),
        .scl_o(scl),
        .sda_low_o(sda_low),
        .wp_o(wp)
    );
    dual_mode_link_recovery_ctrl #(
        .TIME_BASE_CYC(TB_CYC),
        .TIMEOUT_TICKS(TB_TICKS)
    ) dut_u (
        .ref_clk_i(ref_clk_i),
        .resetn_i(resetn_i),
        .transmit_only_clock_i(transmit_only_clock),
        .scl_i(scl),
        .sda_i(sda_wire),
        .sda_o(sda_o),
        .sda_oe_n_o(sda_oe_n_o),
        .write_protect_input_i(wp),
        .has_wc_pin_i(has_wc_pin_i),
        .mem_addr_o(mem_addr_o),
        .mem_data_i(mem_data_i),
        .engine_sda_pull_i(engine_sda_pull_i),
        .engine_wr_commit_i(engine_wr_commit_i),
        .prog_start_o(prog_start_o),
        .write_enable_o(write_enable_o),
        .mode_o(mode_o)
    );

    // compare and count
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // verdict, the single end of the run
    task automatic results();
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // wait whole clocks, landing on a falling edge
    task automatic clks(input int n);
        repeat (n) @(negedge ref_clk_i);
    endtask

    // released init pulses, every byte, then the wrap to zero
    task automatic t_stream();
        logic [7:0] b;
        check(8'(mode_o), 8'(MODE_TX_ONLY));
        for (int p = 0; p < 9; p++) begin
            host_u.transmit_only_clock_pulses(1);
            check(8'(sda_oe_n_o), 8'h01);
        end
        for (int a = 0; a <= 128; a++) begin
            b = {a[6:0], 1'b0} ^ 8'ha5;
            for (int i = 0; i < 9; i++) begin
                host_u.transmit_only_clock_pulses(1);
                check(8'(sda_oe_n_o), (i < 8) ? 8'(b[7 - i]) : 8'h01);
            end
        end
    endtask
    // entry, pulse-count fallback, restart by clock fall, timeout
    task automatic t_fallback();
        host_u.scl_fall();
        check(8'(mode_o), 8'(MODE_TRANSITION));
        host_u.transmit_only_clock_pulses(127);
        check(8'(mode_o), 8'(MODE_TRANSITION));
        host_u.transmit_only_clock_pulses(1);
        check(8'(mode_o), 8'(MODE_TX_ONLY));
        host_u.scl_fall();
        host_u.transmit_only_clock_pulses(100);
        host_u.scl_fall();
        host_u.transmit_only_clock_pulses(127);
        check(8'(mode_o), 8'(MODE_TRANSITION));
        host_u.scl_fall();
        clks(TB_CYC * (TB_TICKS - 1) - 20);
        check(8'(mode_o), 8'(MODE_TRANSITION));
        clks(TB_CYC + 40);
        check(8'(mode_o), 8'(MODE_TX_ONLY));
    endtask
    // wrong type code ignored, right one locks for good
    task automatic t_lock();
        host_u.scl_fall();
        host_u.send_select({~DEV_TYPE_CODE, 4'ha});
        check(8'(mode_o), 8'(MODE_TRANSITION));
        host_u.send_select({DEV_TYPE_CODE, 4'h5});
        check(8'(mode_o), 8'(MODE_LOCKED));
        host_u.transmit_only_clock_pulses(130);
        check(8'(mode_o), 8'(MODE_LOCKED));
    endtask
    // every strap, pin and clock level against a commit
    task automatic t_write();
        logic allow;
        for (int k = 0; k < 8; k++) begin
            has_wc_pin_i = k[2];
            host_u.set_pins(k[1], k[0]);
            allow = k[2] ? k[0] : k[1];
            clks(6);
            check(8'(write_enable_o), 8'(allow));
            engine_wr_commit_i = 1'b1;
            clks(1);
            engine_wr_commit_i = 1'b0;
            check(8'(prog_start_o), 8'(allow));
            clks(1);
            check(8'(prog_start_o), 8'h00);
        end
    endtask
    // engine pulls the line low, otherwise released
    task automatic t_pull();
        engine_sda_pull_i = 1'b1;
        clks(2);
        check(8'(sda_wire), 8'h00);
        engine_sda_pull_i = 1'b0;
        clks(2);
        check(8'(sda_wire), 8'h01);
        check(8'(sda_o), 8'h00);
    endtask

    // reset, then the scenarios in mode order
    initial begin
        has_wc_pin_i       = 1'b0;
        engine_sda_pull_i  = 1'b0;
        engine_wr_commit_i = 1'b0;
        clks(4);
        resetn_i = 1'b1;
        clks(4);
        t_stream();
        t_fallback();
        t_lock();
        t_write();
        t_pull();
        results();
    end
    // watchdog, over twice the expected run
    initial begin
        #400000;
        n_mismatch++;
        results();
    end
endmodule
